// ### verilog/mrx_pkg.sv
// Purpose: Shared constants and types for the receive-side pin block
// Assumes: System clock at 100 MHz, receive link clock on its own port
// Notes:   Each number lives here once; all modules but the MAC model import the whole package
package mrx_pkg;

	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int MRX_NIB_W     = 4;
	localparam int MRX_ADDR_W    = 3;
	localparam int MRX_BUF_DEPTH = 2;

	// ------------------------------------------------------------
	// Strap pin positions feeding each address bit
	// ------------------------------------------------------------
	localparam int MRX_STRAP_PIN_B0 = 3;
	localparam int MRX_STRAP_PIN_B1 = 2;
	localparam int MRX_STRAP_PIN_B2 = 1;

	// ------------------------------------------------------------
	// Values after reset, the enabled-pins value and the buffer full count
	// ------------------------------------------------------------
	localparam logic [MRX_ADDR_W-1:0] MRX_ADDR_RST = 3'h0;
	localparam logic [MRX_NIB_W-1:0]  MRX_RXD_IDLE = 4'h0;
	localparam logic [MRX_NIB_W-1:0]  MRX_OE_OFF   = 4'h0;
	localparam logic [MRX_NIB_W-1:0]  MRX_OE_ON    = 4'hF;
	localparam logic [1:0]            MRX_CNT_FULL = 2'h2;

	// ------------------------------------------------------------
	// Clocks
	// ------------------------------------------------------------
	localparam int MRX_CLK_PERIOD_NS = 10;
	localparam int MRX_REF_CLK_KHZ   = 25000;
	localparam int MRX_REF_PPM       = 50;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [MRX_NIB_W-1:0] data;
	} mrx_nib_t;

	typedef struct packed {
		mrx_nib_t [MRX_BUF_DEPTH-1:0] mem;
		logic                         wptr;
		logic                         rptr;
		logic [1:0]                   count;
		logic                         in_rdy;
	} mrx_buf_st_t;

	typedef struct packed {
		logic [3:1]            pin_meta;
		logic [3:1]            pin_sync;
		logic                  in_rst;
		logic [MRX_ADDR_W-1:0] addr;
		logic                  straps_done;
		logic                  req;
		mrx_nib_t              hold;
		logic                  busy;
		logic [1:0]            ack_sync;
		logic [1:0]            mdc_sync;
		logic [1:0]            mdio_sync;
		logic                  mdc_prev;
		logic                  mgmt_rise;
		logic                  mgmt_data;
		logic                  mdio_oe;
	} mrx_sys_st_t;

	typedef struct packed {
		logic [1:0]           rst_sync;
		logic [1:0]           req_sync;
		logic [1:0]           done_sync;
		logic                 ack;
		logic                 rxdv;
		logic [MRX_NIB_W-1:0] rxd;
		logic [MRX_NIB_W-1:0] oe;
	} mrx_link_st_t;

endpackage : mrx_pkg

// ### verilog/mrx_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Input ready is registered so it can leave the top directly
`timescale 1ns/10ps
`default_nettype none
module mrx_buf (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Filling side
	input  wire logic         in_valid_in,
	input  wire mrx_pkg::mrx_nib_t in_data_in,
	output logic              in_ready_out,
	// Draining side
	output logic              out_valid_out,
	output mrx_pkg::mrx_nib_t out_data_out,
	input  wire logic         out_ready_in
);
	import mrx_pkg::*;

	mrx_buf_st_t b_r;
	mrx_buf_st_t b_nxt;
	logic        push;
	logic        pop;

	assign push          = in_valid_in & b_r.in_rdy;
	assign pop           = out_valid_out & out_ready_in;
	assign out_valid_out = (b_r.count != 2'h0);
	assign out_data_out  = b_r.mem[b_r.rptr];
	assign in_ready_out  = b_r.in_rdy;

	always_comb begin
		b_nxt = b_r;
		if (push) begin
			b_nxt.mem[b_r.wptr] = in_data_in;
			b_nxt.wptr          = ~b_r.wptr;
		end
		if (pop) begin
			b_nxt.rptr = ~b_r.rptr;
		end
		b_nxt.count  = b_r.count + {1'b0, push} - {1'b0, pop};
		b_nxt.in_rdy = (b_nxt.count != MRX_CNT_FULL);
		if (rst_in) begin
			b_nxt        = '0;
			b_nxt.in_rdy = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		b_r <= b_nxt;
	end

endmodule : mrx_buf
`default_nettype wire

// ### verilog/mrx_top.sv
// Purpose: Receive nibble pins, address straps and management pin handling
// Assumes: clock_in is a 100 MHz system clock; rx_link_clk_in is the receive clock, own domain
// Notes:   Nibbles cross to the link domain by a toggle handshake
`timescale 1ns/10ps
`default_nettype none
module mrx_top (
	// System clock and reset
	input  wire logic                           clock_in,
	input  wire logic                           rst_in,
	// Receive link clock
	input  wire logic                           rx_link_clk_in,
	// Nibble stream from the receive path
	input  wire logic                           nib_valid_in,
	input  wire mrx_pkg::mrx_nib_t              nib_data_in,
	output logic                                nib_ready_out,
	// Receive data pins, shared with straps
	input  wire logic [mrx_pkg::MRX_NIB_W-1:0]  mii_rxd_in,
	output logic      [mrx_pkg::MRX_NIB_W-1:0]  mii_rxd_out,
	output logic      [mrx_pkg::MRX_NIB_W-1:0]  mii_rxd_oe_out,
	output logic                                mii_rxdv_out,
	// Management pins
	input  wire logic                           mdc_in,
	input  wire logic                           mdio_in,
	output logic                                mdio_out,
	output logic                                mdio_oe_out,
	input  wire logic                           mdio_drive_low_in,
	output logic                                mgmt_rise_out,
	output logic                                mgmt_data_out,
	// Latched address
	output logic      [mrx_pkg::MRX_ADDR_W-1:0] mgmt_address_bits_out
);
	import mrx_pkg::*;

	mrx_sys_st_t  s_r;
	mrx_sys_st_t  s_nxt;
	mrx_link_st_t l_r;
	mrx_link_st_t l_nxt;
	logic         buf_valid;
	mrx_nib_t     buf_data;
	logic         buf_ready;
	logic         link_rst;
	logic         link_serve;

	// ------------------------------------------------------------
	// Buffer in the data path
	// ------------------------------------------------------------
	assign buf_ready = s_r.straps_done & ~s_r.busy;

	mrx_buf u_buf (
		.clk_in        (clock_in),
		.rst_in        (rst_in),
		.in_valid_in   (nib_valid_in),
		.in_data_in    (nib_data_in),
		.in_ready_out  (nib_ready_out),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_data),
		.out_ready_in  (buf_ready)
	);

	// ------------------------------------------------------------
	// System domain
	// ------------------------------------------------------------
	always_comb begin
		s_nxt           = s_r;
		s_nxt.pin_meta  = mii_rxd_in[3:1];
		s_nxt.pin_sync  = s_r.pin_meta;
		s_nxt.ack_sync  = {s_r.ack_sync[0], l_r.ack};
		s_nxt.mdc_sync  = {s_r.mdc_sync[0], mdc_in};
		s_nxt.mdio_sync = {s_r.mdio_sync[0], mdio_in};
		s_nxt.mdc_prev  = s_r.mdc_sync[1];
		s_nxt.in_rst    = rst_in;
		// Sample management data on the manager's clock edge
		s_nxt.mgmt_rise = s_r.mdc_sync[1] & ~s_r.mdc_prev;
		if (s_r.mdc_sync[1] & ~s_r.mdc_prev) begin
			s_nxt.mgmt_data = s_r.mdio_sync[1];
		end
		// Pull low or release, never drive high
		s_nxt.mdio_oe = mdio_drive_low_in & s_r.straps_done;
		// Strap capture on the first cycle after release
		if (s_r.in_rst && !rst_in) begin
			s_nxt.addr[0]     = s_r.pin_sync[MRX_STRAP_PIN_B0];
			s_nxt.addr[1]     = s_r.pin_sync[MRX_STRAP_PIN_B1];
			s_nxt.addr[2]     = s_r.pin_sync[MRX_STRAP_PIN_B2];
			s_nxt.straps_done = 1'b1;
		end
		// Handshake: hand one nibble at a time to the link side
		if (s_r.busy && (s_r.ack_sync[1] == s_r.req)) begin
			s_nxt.busy = 1'b0;
		end
		if (buf_valid && buf_ready) begin
			s_nxt.hold = buf_data;
			s_nxt.req  = ~s_r.req;
			s_nxt.busy = 1'b1;
		end
		if (rst_in) begin
			s_nxt.addr        = MRX_ADDR_RST;
			s_nxt.straps_done = 1'b0;
			s_nxt.req         = 1'b0;
			s_nxt.hold        = '0;
			s_nxt.busy        = 1'b0;
			s_nxt.mgmt_rise   = 1'b0;
			s_nxt.mgmt_data   = 1'b0;
			s_nxt.mdio_oe     = 1'b0;
			// Clock pin idles high on its pull-up: no false edge after reset
			s_nxt.mdc_prev    = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		s_r <= s_nxt;
	end

	// Address stays put until the next reset
	assign mgmt_address_bits_out = s_r.addr;
	assign mdio_out              = 1'b0;
	assign mdio_oe_out           = s_r.mdio_oe;
	assign mgmt_rise_out         = s_r.mgmt_rise;
	assign mgmt_data_out         = s_r.mgmt_data;

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	assign link_rst   = l_r.rst_sync[1];
	assign link_serve = (l_r.req_sync[1] != l_r.ack);

	always_comb begin
		l_nxt           = l_r;
		l_nxt.rst_sync  = {l_r.rst_sync[0], rst_in};
		l_nxt.req_sync  = {l_r.req_sync[0], s_r.req};
		l_nxt.done_sync = {l_r.done_sync[0], s_r.straps_done};
		// Pins turn to outputs only once straps are taken
		l_nxt.oe = l_r.done_sync[1] ? MRX_OE_ON : MRX_OE_OFF;
		// Nibble and valid flag launched on the receive clock
		if (link_serve) begin
			l_nxt.ack  = ~l_r.ack;
			l_nxt.rxdv = 1'b1;
			l_nxt.rxd  = s_r.hold.data;
		end else begin
			l_nxt.rxdv = 1'b0;
			l_nxt.rxd  = MRX_RXD_IDLE;
		end
		if (link_rst) begin
			l_nxt.ack  = 1'b0;
			l_nxt.rxdv = 1'b0;
			l_nxt.rxd  = MRX_RXD_IDLE;
			l_nxt.oe   = MRX_OE_OFF;
		end
	end

	always_ff @(posedge rx_link_clk_in) begin
		l_r <= l_nxt;
	end

	assign mii_rxd_out    = l_r.rxd;
	assign mii_rxd_oe_out = l_r.oe;
	assign mii_rxdv_out   = l_r.rxdv;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_strap_bit_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_r.in_rst && !rst_in) |=> mgmt_address_bits_out[0] == $past(s_r.pin_sync[3]))
		else $error("address bit 0 not taken from line 3 strap");

	a_strap_bit_one: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_r.in_rst && !rst_in) |=> mgmt_address_bits_out[1] == $past(s_r.pin_sync[2]))
		else $error("address bit 1 not taken from line 2 strap");

	a_strap_bit_two: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_r.in_rst && !rst_in) |=> mgmt_address_bits_out[2] == $past(s_r.pin_sync[1]))
		else $error("address bit 2 not taken from line 1 strap");

	a_addr_hold_stable: assert property (@(posedge clock_in) disable iff (rst_in)
		(!s_r.in_rst && !rst_in) |=> $stable(mgmt_address_bits_out))
		else $error("latched address changed outside reset");

	a_pins_undriven_reset: assert property (@(posedge rx_link_clk_in) disable iff (link_rst)
		!l_r.done_sync[1] |=> (mii_rxd_oe_out == MRX_OE_OFF) && !mii_rxdv_out)
		else $error("strap pins driven before straps taken");

	a_rxd_idle_between: assert property (@(posedge rx_link_clk_in) disable iff (link_rst)
		!link_serve |=> !mii_rxdv_out && (mii_rxd_out == MRX_RXD_IDLE))
		else $error("receive nibble changed without a word to send");

	a_rxdv_data_match: assert property (@(posedge rx_link_clk_in) disable iff (link_rst)
		link_serve |=> mii_rxdv_out && (mii_rxd_out == $past(s_r.hold.data)) ##1 (l_r.ack == l_r.req_sync[1]))
		else $error("valid flag without the handed nibble");

	a_mdio_open_drain: assert property (@(posedge clock_in) disable iff (rst_in)
		mdio_oe_out |-> !mdio_out && $past(mdio_drive_low_in) && s_r.straps_done)
		else $error("management pin driven other than low");

	c_strap_capture: cover property (@(posedge clock_in) s_r.in_rst ##1 !s_r.in_rst && s_r.straps_done);

	c_nibble_served: cover property (@(posedge rx_link_clk_in) disable iff (link_rst)
		!mii_rxdv_out ##1 mii_rxdv_out);

	c_buffer_full: cover property (@(posedge clock_in) disable iff (rst_in) !nib_ready_out ##1 nib_ready_out);

	c_mdio_pull_low: cover property (@(posedge clock_in) disable iff (rst_in) mdio_oe_out ##1 !mdio_oe_out);

endmodule : mrx_top
`default_nettype wire

// ### bench/mrx_mac_model.sv
// Purpose: MAC side of the receive nibble pins
// Assumes: Nibbles sampled on the receive clock rising edge
// Notes:   Data lines are ignored while valid is low
`timescale 1ns/10ps
`default_nettype none
module mrx_mac_model (
	// Receive pins
	input wire logic       rx_link_clk_in,
	input wire logic       rxdv_in,
	input wire logic [3:0] rxd_in
);
	logic [3:0] got [$];

	always @(posedge rx_link_clk_in) begin
		if (rxdv_in === 1'b1) begin
			got.push_back(rxd_in);
		end
	end
endmodule : mrx_mac_model
`default_nettype wire

// ### bench/mrx_top_tb.sv
// Purpose: Self-checking bench for the receive pin block
// Assumes: Straps set by bench pulls, manager released means high
// Notes:   Reset is held long enough for the link side to see it
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module mrx_top_tb;
	import mrx_pkg::*;
	logic            clock_in = 1'b0;
	logic            rst_in   = 1'b1;
	logic            lclk     = 1'b0;
	logic            nib_v    = 1'b0;
	logic            mdc      = 1'b0;
	logic            mgr      = 1'b1;
	logic            dlow     = 1'b0;
	mrx_nib_t        nib_d    = '0;
	logic [3:0]      strap    = 4'h0;
	logic [3:0]      rxd_o;
	logic [3:0]      oe;
	wire logic [3:0] rxd_w;
	wire logic       mdio_w;
	logic            rdy;
	logic            rxdv;
	logic            mdio_o;
	logic            mdio_oe;
	logic            rise;
	logic            mdat;
	logic [2:0]      addr;
	int              n_fail     = 0;
	int              n_compared = 0;
	logic [3:0]      exp_q [$];

	// Pin levels: driven value, else the board pull
	assign rxd_w  = (oe & rxd_o) | (~oe & strap);
	assign mdio_w = mdio_oe ? 1'b0 : mgr;

	// System clock from the package clock period
	always #(MRX_CLK_PERIOD_NS / 2) clock_in = ~clock_in;
	always #80 lclk = ~lclk;

	mrx_top dut (
		.clock_in              (clock_in),
		.rst_in                (rst_in),
		.rx_link_clk_in        (lclk),
		.nib_valid_in          (nib_v),
		.nib_data_in           (nib_d),
		.nib_ready_out         (rdy),
		.mii_rxd_in            (rxd_w),
		.mii_rxd_out           (rxd_o),
		.mii_rxd_oe_out        (oe),
		.mii_rxdv_out          (rxdv),
		.mdc_in                (mdc),
		.mdio_in               (mdio_w),
		.mdio_out              (mdio_o),
		.mdio_oe_out           (mdio_oe),
		.mdio_drive_low_in     (dlow),
		.mgmt_rise_out         (rise),
		.mgmt_data_out         (mdat),
		.mgmt_address_bits_out (addr)
	);

	mrx_mac_model mac (
		.rx_link_clk_in (lclk),
		.rxdv_in        (rxdv),
		.rxd_in         (rxd_o)
	);

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : tick

	task automatic end_sim();
		if (n_fail == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic fail_out();
		n_fail++;
		$display("unexpected at %0t: wait ran out", $time);
		end_sim();
	endtask : fail_out

	task automatic strap_reset(input logic [2:0] a);
		int         i;
		logic [3:0] s;
		s      = {a[0], a[1], a[2], 1'b0};
		strap  = s;
		rst_in = 1'b1;
		tick(60);
		`CHK(oe, MRX_OE_OFF)
		rst_in = 1'b0;
		tick(2);
		`CHK(addr[0], s[3])
		`CHK(addr[1], s[2])
		`CHK(addr[2], s[1])
		strap = ~s;
		tick(2);
		`CHK(addr, {s[1], s[2], s[3]})
		for (i = 0; i < 100 && oe !== MRX_OE_ON; i++) tick();
		`CHK(oe, MRX_OE_ON)
		if (oe !== MRX_OE_ON) fail_out();
		tick(40);
		`CHK(addr, {s[1], s[2], s[3]})
	endtask : strap_reset

	initial begin
		int   i;
		int   k;
		logic ok;
		void'($urandom(32'hE024455F));
		for (k = 0; k < 8; k++) strap_reset(3'(k));
		// Stream with random gaps; slow link side stalls the buffer
		for (k = 0; k < 24; k++) begin
			nib_d.data = 4'($urandom);
			nib_v      = 1'b1;
			exp_q.push_back(nib_d.data);
			for (i = 0; i < 300; i++) begin
				ok = (rdy === 1'b1);
				tick();
				if (ok) break;
			end
			if (i == 300) fail_out();
			if ($urandom_range(3) == 0) begin
				nib_v = 1'b0;
				tick();
			end
		end
		nib_v = 1'b0;
		for (i = 0; i < 3000 && mac.got.size() < 24; i++) tick();
		if (mac.got.size() != 24) fail_out();
		for (k = 0; k < 24; k++) `CHK(mac.got[k], exp_q[k])
		// Management clock edges with the data pin pulled or released
		for (k = 0; k < 8; k++) begin
			dlow = 1'($urandom_range(1));
			mgr  = 1'($urandom_range(1));
			tick();
			`CHK(mdio_oe, dlow)
			`CHK(mdio_o, 1'b0)
			mdc = 1'b1;
			for (i = 0; i < 10 && rise !== 1'b1; i++) tick();
			`CHK(rise, 1'b1)
			if (rise !== 1'b1) fail_out();
			`CHK(mdat, mdio_w)
			tick();
			mdc = 1'b0;
			tick(4);
		end
		end_sim();
	end
endmodule : mrx_top_tb
`default_nettype wire
